// ---- shared/barrier_map.svh ----
`ifndef BARRIER_MAP_SVH
`define BARRIER_MAP_SVH
`define STYPE_MSB        10
`define STYPE_LSB        6
`define STYPE_FULL       5'h00
`define STYPE_WMB        5'h04
`define STYPE_MB         5'h10
`define STYPE_ACQUIRE    5'h11
`define STYPE_RELEASE    5'h12
`define STYPE_RMB        5'h13
`define CNT_ZERO         8'h00
`define CNT_ONE          8'h01
`endif

// ---- shared/barrier_pkg.sv ----
package barrier_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DRAIN = 2'b01,
    ST_DONE  = 2'b11
  } bar_state_e;

  // Memory access class as seen by the barrier.
  typedef enum logic [1:0] {
    OP_LOAD  = 2'b00,
    OP_STORE = 2'b01,
    OP_CACHE = 2'b10,
    OP_PREFETCH = 2'b11
  } op_kind_e;

  typedef enum logic [1:0] {
    CCA_UNCACHED = 2'b00,
    CCA_COHERENT = 2'b01,
    CCA_NONCOH   = 2'b10,
    CCA_OTHER    = 2'b11
  } cca_e;
endpackage : barrier_pkg

// ---- rtl/barrier_decode.sv ----
`timescale 1ns/1ns
`include "barrier_map.svh"
module barrier_decode (
  input  wire logic [31:0] instr,        // Barrier instruction word.
  output logic             older_ld,     // Older loads are selected.
  output logic             older_st,     // Older stores are selected.
  output logic             younger_ld,   // Younger loads are held.
  output logic             younger_st,   // Younger stores are held.
  output logic             completion    // Full completion semantics.
);
  logic [4:0] stype;

  assign stype = instr[`STYPE_MSB:`STYPE_LSB];

  always_comb begin
    older_ld   = 1'b1;
    older_st   = 1'b1;
    younger_ld = 1'b1;
    younger_st = 1'b1;
    completion = 1'b0;
    case (stype)
      `STYPE_WMB: begin
        older_ld   = 1'b0;
        younger_ld = 1'b0;
      end
      `STYPE_MB: begin
      end
      `STYPE_RMB: begin
        older_st   = 1'b0;
        younger_st = 1'b0;
      end
      `STYPE_ACQUIRE: begin
        older_st = 1'b0;
      end
      `STYPE_RELEASE: begin
        younger_ld = 1'b0;
      end
      // Type zero, vendor codes and reserved codes all act as full sync.
      default: begin
        completion = 1'b1;
      end
    endcase
  end
endmodule : barrier_decode

// ---- rtl/memory_barrier_ordering.sv ----
`timescale 1ns/1ns
`include "barrier_map.svh"
// Notes on behaviour
// - Only uncached and cached coherent accesses are constrained.
// - A completion barrier holds younger selected ops until older ones end.
// - Loads end at register writeback, stores once globally visible.
// - Older selected accesses are globally performed before younger ones.
// - Instruction fetches are never ordered by the barrier.
// - Type zero is the full load and store completion barrier.
// - Undefined nonzero types execute as the type zero barrier.
// - Ordering barriers keep older accesses ahead at the ordering point.
// - External requests of older ops are performed before younger ones.
// - Ordering barriers finish without waiting for older completion.
// - Cache and prefetch ops count as loads or stores, per issue_is_ld.
// - The type field is instruction bits ten down to six.
// - Types 0x4, 0x10 and 0x13 order stores, both, and loads.
// - Type 0x11 is acquire and type 0x12 is release.
// - Vendor and reserved codes fall back to the full barrier.
module memory_barrier_ordering #(
  parameter int CNT_W = 8
) (
  input  wire logic                  clk,           // Core clock.
  input  wire logic                  rst,           // Sync reset, high.
  input  wire logic                  bar_valid,     // Barrier at issue.
  input  wire logic [31:0]           bar_instr,     // Barrier word.
  input  wire logic                  issue_valid,   // Memory op issued.
  input  wire barrier_pkg::op_kind_e issue_kind,    // Its kind.
  input  wire logic                  issue_is_ld,   // Cache/prefetch_op as load.
  input  wire barrier_pkg::cca_e     issue_cca,     // Its access type.
  input  wire logic                  ld_done,       // Load wrote register.
  input  wire logic                  st_done,       // Store globally seen.
  input  wire logic                  ld_ordered,    // Load past order pt.
  input  wire logic                  st_ordered,    // Store past order pt.
  output logic                       bar_stall,     // Barrier held.
  output logic                       bar_retire,    // Barrier done pulse.
  output logic                       hold_ld,       // Hold younger loads.
  output logic                       hold_st        // Hold younger stores.
);
  import barrier_pkg::*;

  // ============================================================
  // Outstanding counters
  // ============================================================
  // Two counters per class: not yet past the ordering point, and not yet
  // completed. The pipeline reports done/ordered only for synchronizable
  // ops it was told about through issue_valid.
  logic             sync_op;
  logic             op_ld;
  logic             op_st;
  logic [CNT_W-1:0] ld_pend_q;
  logic [CNT_W-1:0] st_pend_q;
  logic [CNT_W-1:0] ld_unord_q;
  logic [CNT_W-1:0] st_unord_q;

  assign sync_op = issue_valid &&
                   (issue_cca == CCA_UNCACHED ||
                    issue_cca == CCA_COHERENT);
  // Cache maintenance and prefetch ride the same counters.
  assign op_ld = sync_op && (issue_kind == OP_LOAD ||
                 (issue_kind != OP_STORE && issue_is_ld));
  assign op_st = sync_op && (issue_kind == OP_STORE ||
                 (issue_kind != OP_LOAD && !issue_is_ld));

  function automatic logic [CNT_W-1:0] step(
    input logic [CNT_W-1:0] c, input logic inc, input logic dec);
    logic [CNT_W-1:0] one;
    one = CNT_W'(`CNT_ONE);
    if (inc && !dec) begin
      step = c + one;
    end else if (dec && !inc && c != CNT_W'(`CNT_ZERO)) begin
      step = c - one;
    end else begin
      step = c;
    end
  endfunction : step

  always_ff @(posedge clk) begin
    if (rst) begin
      ld_pend_q  <= CNT_W'(`CNT_ZERO);
      st_pend_q  <= CNT_W'(`CNT_ZERO);
      ld_unord_q <= CNT_W'(`CNT_ZERO);
      st_unord_q <= CNT_W'(`CNT_ZERO);
    end else begin
      ld_pend_q  <= step(ld_pend_q, op_ld, ld_done);
      st_pend_q  <= step(st_pend_q, op_st, st_done);
      ld_unord_q <= step(ld_unord_q, op_ld, ld_ordered);
      st_unord_q <= step(st_unord_q, op_st, st_ordered);
    end
  end

  // ============================================================
  // Type decode
  // ============================================================
  logic sel_old_ld;
  logic sel_old_st;
  logic sel_yng_ld;
  logic sel_yng_st;
  logic sel_full;

  barrier_decode u_decode (
    .instr      (bar_instr),
    .older_ld   (sel_old_ld),
    .older_st   (sel_old_st),
    .younger_ld (sel_yng_ld),
    .younger_st (sel_yng_st),
    .completion (sel_full)
  );

  // ============================================================
  // Barrier sequencer
  // ============================================================
  // The selection is latched at acceptance so the condition does not
  // shift if the pipeline changes bar_instr while stalled.
  bar_state_e state_q;
  logic       old_ld_q;
  logic       old_st_q;
  logic       yng_ld_q;
  logic       yng_st_q;
  logic       full_q;
  logic       met;

  always_comb begin
    if (full_q) begin
      met = (!old_ld_q || ld_pend_q == CNT_W'(`CNT_ZERO)) &&
            (!old_st_q || st_pend_q == CNT_W'(`CNT_ZERO));
    end else begin
      // Ordering barrier: older ops only need to pass the ordering
      // point, after which the datapath keeps external order.
      met = (!old_ld_q || ld_unord_q == CNT_W'(`CNT_ZERO)) &&
            (!old_st_q || st_unord_q == CNT_W'(`CNT_ZERO));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= ST_IDLE;
      old_ld_q <= 1'b0;
      old_st_q <= 1'b0;
      yng_ld_q <= 1'b0;
      yng_st_q <= 1'b0;
      full_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (bar_valid) begin
            old_ld_q <= sel_old_ld;
            old_st_q <= sel_old_st;
            yng_ld_q <= sel_yng_ld;
            yng_st_q <= sel_yng_st;
            full_q   <= sel_full;
            state_q  <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (met) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Outputs
  // ============================================================
  // Holds cover data accesses only; the fetch path has no hold at all.
  always_ff @(posedge clk) begin
    if (rst) begin
      bar_stall  <= 1'b0;
      bar_retire <= 1'b0;
      hold_ld    <= 1'b0;
      hold_st    <= 1'b0;
    end else begin
      bar_stall  <= (state_q == ST_IDLE && bar_valid) ||
                    (state_q == ST_DRAIN && !met);
      bar_retire <= state_q == ST_DRAIN && met;
      hold_ld    <= state_q == ST_IDLE ? (bar_valid && sel_yng_ld)
                    : (state_q == ST_DRAIN && !met && yng_ld_q);
      hold_st    <= state_q == ST_IDLE ? (bar_valid && sel_yng_st)
                    : (state_q == ST_DRAIN && !met && yng_st_q);
    end
  end
endmodule : memory_barrier_ordering

// ---- sim/barrier_checker.sv ----
`timescale 1ns/1ns
module barrier_checker (
  input wire logic        clk,        // Core clock.
  input wire logic        rst,        // Sync reset.
  input wire logic        bar_valid,  // Barrier at issue.
  input wire logic [31:0] bar_instr,  // Barrier word.
  input wire logic        bar_stall,  // Barrier held.
  input wire logic        bar_retire, // Retire pulse.
  input wire logic        hold_ld,    // Younger loads held.
  input wire logic        hold_st     // Younger stores held.
);
  logic       idle;
  logic [4:0] ty;
  assign idle = !bar_stall && !bar_retire;
  assign ty   = bar_instr[10:6];
  // ==========================================================
  // Take, hold and release
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rst_quiet_a: assert property (disable iff (1'b0) rst |=>
    !bar_stall && !bar_retire && !hold_ld && !hold_st)
    else $error("outputs not cleared by reset");
  take_stall_a: assert property (idle && bar_valid |=> bar_stall)
    else $error("barrier not stalled after take");
  full_hold_a: assert property (idle && bar_valid &&
    ty inside {5'h00, 5'h01, 5'h14, 5'h1f} |=> hold_ld && hold_st)
    else $error("full barrier holds wrong");
  store_hold_a: assert property (idle && bar_valid && ty == 5'h04
    |=> hold_st && !hold_ld) else $error("store barrier holds wrong");
  load_hold_a: assert property (idle && bar_valid && ty == 5'h13
    |=> hold_ld && !hold_st) else $error("load barrier holds wrong");
  release_hold_a: assert property (idle && bar_valid && ty == 5'h12
    |=> hold_st && !hold_ld) else $error("release holds wrong");
  retire_drop_a: assert property (bar_retire |->
    !bar_stall && !hold_ld && !hold_st ##1 !bar_retire)
    else $error("retire pulse or release wrong");
  retire_late_a: assert property (bar_retire |-> $past(bar_stall))
    else $error("retire without prior stall");
  hold_steady_a: assert property (bar_stall && $past(bar_stall)
    |-> $stable({hold_ld, hold_st})) else $error("holds changed");
endmodule : barrier_checker

// ---- sim/mem_model.sv ----
`timescale 1ns/1ns
// ==========================================================
// Memory side: a tracked op passes the order point after lat
// cycles and completes lat-1 cycles later. One op per class
// may be in flight at a time, which the bench keeps to.
module mem_model (
  input  wire logic                  clk,         // Core clock.
  input  wire logic                  rst,         // Sync reset.
  input  wire logic [7:0]            lat,         // Delay, above 0.
  input  wire logic                  issue_valid, // Op issued.
  input  wire barrier_pkg::op_kind_e issue_kind,  // Its kind.
  input  wire logic                  issue_is_ld, // Counts as load.
  input  wire barrier_pkg::cca_e     issue_cca,   // Access type.
  output logic                       ld_done,     // Load done.
  output logic                       st_done,     // Store seen.
  output logic                       ld_ordered,  // Load ordered.
  output logic                       st_ordered   // Store ordered.
);
  import barrier_pkg::*;
  logic       trk;
  logic       is_ld;
  logic [8:0] ld_t_q;
  logic [8:0] st_t_q;
  assign trk   = issue_valid && (issue_cca inside {CCA_UNCACHED, CCA_COHERENT});
  assign is_ld = (issue_kind == OP_LOAD) ||
                 ((issue_kind inside {OP_CACHE, OP_PREFETCH}) && issue_is_ld);
  always_ff @(posedge clk) begin
    if (rst) ld_t_q <= 9'h000;
    else if (trk && is_ld) ld_t_q <= {lat, 1'b0};
    else if (ld_t_q != 9'h000) ld_t_q <= ld_t_q - 9'h001;
  end
  always_ff @(posedge clk) begin
    if (rst) st_t_q <= 9'h000;
    else if (trk && !is_ld) st_t_q <= {lat, 1'b0};
    else if (st_t_q != 9'h000) st_t_q <= st_t_q - 9'h001;
  end
  assign ld_ordered = (ld_t_q == {1'b0, lat});
  assign st_ordered = (st_t_q == {1'b0, lat});
  assign ld_done    = (ld_t_q == 9'h001);
  assign st_done    = (st_t_q == 9'h001);
endmodule : mem_model

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import barrier_pkg::*;
  // Entry: type, completion, older st, older ld, hold st, hold ld.
  localparam logic [9:0] TBL [9] = '{10'h01f, 10'h08a, 10'h20f, 10'h227,
    10'h24e, 10'h265, 10'h03f, 10'h29f, 10'h3ff};
  logic        clk = 1'b0, rst = 1'b1, bar_valid = 1'b0, issue_valid = 1'b0;
  logic        issue_is_ld = 1'b0, ld_done, st_done, ld_ordered, st_ordered;
  logic        bar_stall, bar_retire, hold_ld, hold_st;
  logic [31:0] bar_instr = 32'h0000_0000;
  op_kind_e    issue_kind = OP_LOAD;
  cca_e        issue_cca = CCA_COHERENT;
  int          n_fail = 0, n_checks = 0, lc_d, lc_o, sc_d, sc_o;
  always #20 clk = ~clk;
  always @(negedge clk) begin
    lc_d += ld_done;
    lc_o += ld_ordered;
    sc_d += st_done;
    sc_o += st_ordered;
  end
  memory_barrier_ordering u_dut (.clk(clk), .rst(rst), .bar_valid(bar_valid),
    .bar_instr(bar_instr), .issue_valid(issue_valid), .issue_kind(issue_kind),
    .issue_is_ld(issue_is_ld), .issue_cca(issue_cca), .ld_done(ld_done),
    .st_done(st_done), .ld_ordered(ld_ordered), .st_ordered(st_ordered),
    .bar_stall(bar_stall), .bar_retire(bar_retire), .hold_ld(hold_ld),
    .hold_st(hold_st));
  mem_model u_mem (.clk(clk), .rst(rst), .lat(8'h0a),
    .issue_valid(issue_valid), .issue_kind(issue_kind),
    .issue_is_ld(issue_is_ld), .issue_cca(issue_cca), .ld_done(ld_done),
    .st_done(st_done), .ld_ordered(ld_ordered), .st_ordered(st_ordered));
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic issue(input op_kind_e k, input logic l, input cca_e c);
    @(posedge clk);
    issue_valid <= 1'b1;
    issue_kind  <= k;
    issue_is_ld <= l;
    issue_cca   <= c;
    @(posedge clk);
    issue_valid <= 1'b0;
  endtask : issue
  // Holds are taken in the first stalled cycle; counts at retire.
  task automatic run_bar(input logic [4:0] ty, output int cyc,
                         output logic [1:0] hl, output logic [3:0] n);
    cyc = 0;
    @(posedge clk);
    bar_valid <= 1'b1;
    bar_instr <= {21'h000000, ty, 6'h00};
    do begin
      @(negedge clk);
      cyc++;
      if (cyc == 2) hl = {hold_ld, hold_st};
      if (cyc > 100) begin
        n_fail++;
        close_out();
      end
    end while (bar_retire !== 1'b1);
    n = {lc_d[0], lc_o[0], sc_d[0], sc_o[0]};
    check("stall at retire", {7'h00, bar_stall}, 8'h00);
    @(posedge clk);
    bar_valid <= 1'b0;
  endtask : run_bar
  task automatic t_empty;
    int c;
    logic [1:0] h;
    logic [3:0] n;
    issue(OP_LOAD, 1'b1, CCA_NONCOH);
    run_bar(5'h00, c, h, n);
    check("empty cycles", c[7:0], 8'h03);
    check("full holds", {6'h00, h}, 8'h03);
    $display("test empty done");
  endtask : t_empty
  task automatic t_types;
    int c;
    logic [1:0] h;
    logic [3:0] n;
    logic [9:0] e;
    for (int i = 0; i < 9; i++) begin
      e = TBL[i];
      lc_d = 0;
      lc_o = 0;
      sc_d = 0;
      sc_o = 0;
      issue(i[0] ? OP_CACHE : OP_LOAD, 1'b1, CCA_COHERENT);
      issue(i[0] ? OP_PREFETCH : OP_STORE, 1'b0, CCA_UNCACHED);
      run_bar(e[9:5], c, h, n);
      // The table keeps the store hold above the load hold; h is the other
      // way round, so the two expected bits are swapped here.
      check("holds", {6'h00, h}, {6'h00, e[0], e[1]});
      if (e[2]) check("older load", {7'h00, e[4] ? n[3] : n[2]}, 8'h01);
      if (e[3]) check("old store", {7'h00, e[4] ? n[1] : n[0]}, 8'h01);
      if (!e[4]) check("early finish", {6'h00, n[3], n[1]}, 8'h00);
      repeat (24) @(posedge clk);
    end
    $display("test types done");
  endtask : t_types
  initial begin
    repeat (11) @(posedge clk);
    @(negedge clk);
    check("reset outs", {4'h0, bar_stall, bar_retire, hold_ld, hold_st},
          8'h00);
    @(posedge clk);
    rst <= 1'b0;
    t_empty();
    t_types();
    close_out();
  end
endmodule : tb_top
bind memory_barrier_ordering barrier_checker u_chk (.clk(clk), .rst(rst),
  .bar_valid(bar_valid), .bar_instr(bar_instr), .bar_stall(bar_stall),
  .bar_retire(bar_retire), .hold_ld(hold_ld), .hold_st(hold_st));
